// ---- latch_input_select_output_invert.sv ----
// latch input routing and output terminal inversion with apb setting registers
// Contract
// - codes 0-4 and 8-C hold latch inactive
// - codes 5-7 route terminal five-seven, active ON
// - codes D-F route terminal five-seven, active OFF
// - separate digits for latch two and three
// - latch two/three digits decode like latch one
// - per output inversion bit, 1 complements
// - lowest digit selects latch signal one
`timescale 1ns/1ps
`include "latch_sel_defs.svh"
module latch_input_select_output_invert
(
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // connector inputs
   input  wire logic        input_terminal_five,
   input  wire logic        input_terminal_six,
   input  wire logic        input_terminal_seven,
   // internal output states, terminal zero first
   input  wire logic [3:0]  out_state,
   // routed latch signals and output terminals
   output logic             latch_signal_one,
   output logic             latch_signal_two,
   output logic             latch_signal_three,
   output logic      [3:0]  output_terminal
);
   import latch_sel_pkg::*;

   sel_state_t s_reg;
   sel_state_t s_next;

   function automatic logic route_latch(input sel_digit_t code, input logic [2:0] term);
      logic hit;
      hit = 1'b0;
      if (code >= `SEL_CODE_ON_LO && code <= `SEL_CODE_ON_HI)
      begin
         hit = term[2'(code - `SEL_CODE_ON_LO)];
      end
      else if (code >= `SEL_CODE_OFF_LO)
      begin
         hit = ~term[2'(code - `SEL_CODE_OFF_LO)];
      end
      // all other codes leave hit low
      return hit;
   endfunction : route_latch

   logic [2:0]  terms;
   logic        wr_acc;
   logic        rd_acc;
   assign terms  = {input_terminal_seven, input_terminal_six, input_terminal_five};
   // pready high blocks a second take before the master drops penable
   assign wr_acc = psel && penable && pwrite && !s_reg.pready_reg;
   assign rd_acc = psel && penable && !pwrite && !s_reg.pready_reg;

   always_comb
   begin
      s_next = s_reg;
      s_next.pready_reg  = 1'b0;
      s_next.pslverr_reg = 1'b0;
      if (wr_acc || rd_acc)
      begin
         s_next.pready_reg = 1'b1;
         if (paddr == `SEL_ADDR_INPUT)
         begin
            if (wr_acc)
            begin
               s_next.input_assign_setting_reg = pwdata;
               s_next.pending_reg = 1'b1;
            end
            s_next.prdata_reg = s_reg.input_assign_setting_reg;
         end
         else if (paddr == `SEL_ADDR_LATCH_OUT)
         begin
            if (wr_acc)
            begin
               // upper half has no fields, so it never stores
               s_next.latch_and_output_setting_reg = {16'h0000, pwdata[15:0]};
               s_next.pending_reg = 1'b1;
            end
            s_next.prdata_reg = s_reg.latch_and_output_setting_reg;
         end
         else if (paddr == `SEL_ADDR_STATUS)
         begin
            s_next.prdata_reg = {24'h000000, s_reg.pending_reg, s_reg.out_term_reg,
                                 s_reg.latch_reg};
         end
         else if (paddr == `SEL_ADDR_RESTART)
         begin
            // a restart key copies the stored latch and output setting into the live set
            if (wr_acc && pwdata == `SEL_RESTART_KEY)
            begin
               s_next.active_setting_reg =
                  s_reg.latch_and_output_setting_reg[15:0];
               s_next.pending_reg = 1'b0;
            end
            s_next.prdata_reg = 32'h0000_0000;
         end
         else
         begin
            s_next.pslverr_reg = 1'b1;
            s_next.prdata_reg  = 32'h0000_0000;
         end
         if (!rd_acc)
         begin
            s_next.prdata_reg = 32'h0000_0000;
         end
      end
      // live routing uses only the latched copy, never the pending one
      s_next.latch_reg[0] = route_latch(s_reg.active_setting_reg[3:0], terms);
      s_next.latch_reg[1] = route_latch(s_reg.active_setting_reg[7:4], terms);
      s_next.latch_reg[2] = route_latch(s_reg.active_setting_reg[11:8], terms);
      s_next.out_term_reg = out_state ^ s_reg.active_setting_reg[15:12];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // live set clears too, so routing restarts all inactive
         s_reg.input_assign_setting_reg     <= `SEL_INPUT_RESET;
         s_reg.latch_and_output_setting_reg <= `SEL_LATCH_OUT_RESET;
         s_reg.active_setting_reg           <= 16'(`SEL_LATCH_OUT_RESET);
         s_reg.latch_reg                    <= 3'h0;
         s_reg.out_term_reg                 <= 4'h0;
         s_reg.prdata_reg                   <= 32'h0000_0000;
         s_reg.pready_reg                   <= 1'b0;
         s_reg.pslverr_reg                  <= 1'b0;
         s_reg.pending_reg                  <= 1'b0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign prdata             = s_reg.prdata_reg;
   assign pready             = s_reg.pready_reg;
   assign pslverr            = s_reg.pslverr_reg;
   assign latch_signal_one   = s_reg.latch_reg[0];
   assign latch_signal_two   = s_reg.latch_reg[1];
   assign latch_signal_three = s_reg.latch_reg[2];
   assign output_terminal    = s_reg.out_term_reg;

   // latches are registered, so each check but chk_err_with_ready looks one edge on
   chk_code_inactive: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[3:0] <= 4'h4)
      |=> !latch_signal_one)
      else $error("latch one active for inactive code");

   chk_on_route: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[7:4] == 4'h6)
      |=> latch_signal_two == $past(input_terminal_six))
      else $error("latch two not following terminal six");

   chk_off_route: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[11:8] == 4'hF)
      |=> latch_signal_three == !$past(input_terminal_seven))
      else $error("latch three not inverse of terminal seven");

   chk_mid_inactive: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[11:8] inside {[4'h8:4'hC]})
      |=> !latch_signal_three)
      else $error("latch three active for inactive code");

   chk_invert_out: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1
      |=> output_terminal == ($past(out_state) ^ $past(s_reg.active_setting_reg[15:12])))
      else $error("output terminal inversion wrong");

   chk_no_live_change: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == `SEL_ADDR_LATCH_OUT)
      |=> $stable(s_reg.active_setting_reg))
      else $error("setting applied without restart");

   chk_one_digit: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[3:0] == 4'hD)
      |=> latch_signal_one == !$past(input_terminal_five))
      else $error("latch one not inverse of terminal five");

   chk_two_indep: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[7:4] == 4'h0)
      |=> !latch_signal_two)
      else $error("latch two active for code zero");

   chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready)
      |=> pready)
      else $error("apb answer late");

   chk_one_mid_off: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[3:0] inside {[4'h8:4'hC]})
      |=> !latch_signal_one)
      else $error("latch one active for middle code");

   chk_two_low_off: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[7:4] inside {[4'h1:4'h4]})
      |=> !latch_signal_two)
      else $error("latch two active for low code");

   chk_three_low_off: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[11:8] <= 4'h4)
      |=> !latch_signal_three)
      else $error("latch three active for low code");

   chk_on_five: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[3:0] == 4'h5)
      |=> latch_signal_one == $past(input_terminal_five))
      else $error("latch one not following terminal five");

   chk_on_seven: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[11:8] == 4'h7)
      |=> latch_signal_three == $past(input_terminal_seven))
      else $error("latch three not following terminal seven");

   chk_two_on_five: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[7:4] == 4'h5)
      |=> latch_signal_two == $past(input_terminal_five))
      else $error("latch two not following terminal five");

   chk_three_on_six: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[11:8] == 4'h6)
      |=> latch_signal_three == $past(input_terminal_six))
      else $error("latch three not following terminal six");

   chk_one_on_six: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[3:0] == 4'h6)
      |=> latch_signal_one == $past(input_terminal_six))
      else $error("latch one not following terminal six");

   chk_one_on_seven: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[3:0] == 4'h7)
      |=> latch_signal_one == $past(input_terminal_seven))
      else $error("latch one not following terminal seven");

   chk_off_six: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[7:4] == 4'hE)
      |=> latch_signal_two == !$past(input_terminal_six))
      else $error("latch two not inverse of terminal six");

   chk_off_five: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[11:8] == 4'hD)
      |=> latch_signal_three == !$past(input_terminal_five))
      else $error("latch three not inverse of terminal five");

   chk_two_off_seven: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[7:4] == 4'hF)
      |=> latch_signal_two == !$past(input_terminal_seven))
      else $error("latch two not inverse of terminal seven");

   chk_one_off_seven: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[3:0] == 4'hF)
      |=> latch_signal_one == !$past(input_terminal_seven))
      else $error("latch one not inverse of terminal seven");

   chk_out_pass: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[15:12] == 4'h0)
      |=> output_terminal == $past(out_state))
      else $error("output terminal changed without inversion");

   chk_out_all_inv: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.active_setting_reg[15:12] == 4'hF)
      |=> output_terminal == ~$past(out_state))
      else $error("output terminal not fully inverted");

   chk_restart_apply: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == `SEL_ADDR_RESTART && pwdata == `SEL_RESTART_KEY)
      |=> s_reg.active_setting_reg == $past(s_reg.latch_and_output_setting_reg[15:0]))
      else $error("restart did not apply stored setting");

   chk_input_no_live: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == `SEL_ADDR_INPUT)
      |=> $stable(s_reg.active_setting_reg))
      else $error("input setting write changed live set");

   chk_pending_set: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == `SEL_ADDR_LATCH_OUT)
      |=> s_reg.pending_reg)
      else $error("pending not set by setting write");

   chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready
      |=> !pready)
      else $error("apb ready longer than one cycle");

   chk_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr
      |-> pready)
      else $error("apb error without ready");

   cov_restart: cover property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == `SEL_ADDR_RESTART);

   cov_on_hit: cover property (@(posedge pclk) disable iff (!presetn)
      latch_signal_one && s_reg.active_setting_reg[3:0] == 4'h5);

   cov_off_hit: cover property (@(posedge pclk) disable iff (!presetn)
      latch_signal_two && s_reg.active_setting_reg[7:4] == 4'hE);

   cov_all_invert: cover property (@(posedge pclk) disable iff (!presetn)
      s_reg.active_setting_reg[15:12] == 4'hF && output_terminal == 4'h0);

   cov_bad_addr: cover property (@(posedge pclk) disable iff (!presetn)
      pslverr);
endmodule : latch_input_select_output_invert

// ---- latch_sel_defs.svh ----
// constants for the latch input select and output invert block
`ifndef LATCH_SEL_DEFS_SVH
`define LATCH_SEL_DEFS_SVH
`define SEL_ADDR_INPUT       12'h000
`define SEL_ADDR_LATCH_OUT   12'h004
`define SEL_ADDR_STATUS      12'h008
`define SEL_ADDR_RESTART     12'h00C
`define SEL_INPUT_RESET      32'h0000_0000
`define SEL_LATCH_OUT_RESET  32'h0000_0000
`define SEL_DIGIT_W          4
`define SEL_LATCH_N          3
`define SEL_OUT_N            4
`define SEL_INV_LSB          12
`define SEL_CODE_ON_LO       4'h5
`define SEL_CODE_ON_HI       4'h7
`define SEL_CODE_OFF_LO      4'hD
`define SEL_CODE_OFF_HI      4'hF
`define SEL_RESTART_KEY      32'h0000_0001
`endif

// ---- latch_sel_pkg.sv ----
// types for the latch input select and output invert block
package latch_sel_pkg;
   typedef logic [3:0] sel_digit_t;
   typedef struct packed
   {
      logic [31:0] input_assign_setting_reg;
      logic [31:0] latch_and_output_setting_reg;
      logic [15:0] active_setting_reg;
      logic [2:0]  latch_reg;
      logic [3:0]  out_term_reg;
      logic [31:0] prdata_reg;
      logic        pready_reg;
      logic        pslverr_reg;
      logic        pending_reg;
   } sel_state_t;
endpackage : latch_sel_pkg

// ---- field_wiring_model.sv ----
// field wiring model driving the connector input terminals
`timescale 1ns/1ps
module field_wiring_model
(
   // bench side, bit0 = terminal five
   input  wire logic [2:0] pattern,
   // connector side, high = contact closed (ON)
   output logic            input_terminal_five,
   output logic            input_terminal_six,
   output logic            input_terminal_seven
);
   assign {input_terminal_seven, input_terminal_six, input_terminal_five} = pattern;
endmodule : field_wiring_model

// ---- test_latch_input_select_output_invert.sv ----
// testbench for latch input routing and output inversion
`timescale 1ns/1ps
`include "latch_sel_defs.svh"
module test_latch_input_select_output_invert;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic        pready, pslverr, er, l1, l2, l3, t5, t6, t7;
   logic [2:0]  pattern = 3'h0;
   logic [3:0]  out_state = 4'h0, output_terminal;
   logic [15:0] cfg;
   int          err_total = 0, total_checks = 0;
   always #2.5 pclk = ~pclk;
   field_wiring_model i_wire (.pattern(pattern), .input_terminal_five(t5),
      .input_terminal_six(t6), .input_terminal_seven(t7));
   latch_input_select_output_invert i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .input_terminal_five(t5), .input_terminal_six(t6),
      .input_terminal_seven(t7), .out_state(out_state), .latch_signal_one(l1),
      .latch_signal_two(l2), .latch_signal_three(l3), .output_terminal(output_terminal));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   // leading edge keeps psel from being assigned twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20)
      begin
         err_total++;
         tally_and_finish();
      end
   endtask : apb
   // codes 8-C share low bits 0-4 with the inactive codes
   function automatic logic route(input logic [3:0] c, input logic [2:0] t);
      if (c[2:0] >= 3'h5)
         route = t[c[1:0] - 2'h1] ^ c[3];
      else
         route = 1'b0;
   endfunction : route
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `SEL_ADDR_LATCH_OUT, 32'h0);
      check(rd, `SEL_LATCH_OUT_RESET);
      check({31'h0, er}, 32'h0);
      check({29'h0, l3, l2, l1}, 32'h0);
      $display("test reset values done");
      for (int c = 0; c < 16; c++)
      begin
         cfg = {4'(c), 4'(c + 2), 4'(c + 1), 4'(c)};
         apb(1'b1, `SEL_ADDR_LATCH_OUT, {16'h0, cfg});
         apb(1'b1, `SEL_ADDR_RESTART, `SEL_RESTART_KEY);
         for (int p = 0; p < 8; p++)
         begin
            pattern <= 3'(p);
            out_state <= 4'(p * 3);
            repeat (3) @(posedge pclk);
            check({29'h0, l3, l2, l1}, {29'h0, route(cfg[11:8], pattern),
               route(cfg[7:4], pattern), route(cfg[3:0], pattern)});
            check({28'h0, output_terminal}, {28'h0, out_state ^ cfg[15:12]});
         end
      end
      $display("test routing and inversion done");
      pattern <= 3'h1;
      apb(1'b1, `SEL_ADDR_LATCH_OUT, 32'h0000_0555);
      repeat (3) @(posedge pclk);
      // the last live setting must still steer the latches
      check({29'h0, l3, l2, l1}, {29'h0, route(cfg[11:8], pattern),
         route(cfg[7:4], pattern), route(cfg[3:0], pattern)});
      apb(1'b0, `SEL_ADDR_STATUS, 32'h0);
      check({31'h0, rd[7]}, 32'h1);
      apb(1'b1, `SEL_ADDR_RESTART, `SEL_RESTART_KEY);
      repeat (3) @(posedge pclk);
      check({29'h0, l3, l2, l1}, 32'h7);
      apb(1'b0, `SEL_ADDR_STATUS, 32'h0);
      check({24'h0, rd[7:0]}, {24'h0, 1'b0, out_state, 3'h7});
      $display("test restart apply done");
      apb(1'b1, `SEL_ADDR_INPUT, 32'hA5C3_3C5A);
      apb(1'b0, `SEL_ADDR_INPUT, 32'h0);
      check(rd, 32'hA5C3_3C5A);
      apb(1'b0, `SEL_ADDR_STATUS, 32'h0);
      check({31'h0, rd[7]}, 32'h1);
      apb(1'b1, `SEL_ADDR_LATCH_OUT, 32'hFFFF_0555);
      apb(1'b0, `SEL_ADDR_LATCH_OUT, 32'h0);
      check(rd, 32'h0000_0555);
      $display("test setting store done");
      apb(1'b0, 12'h010, 32'h0);
      check(rd, 32'h0);
      check({31'h0, er}, 32'h1);
      $display("test unmapped done");
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      check({29'h0, l3, l2, l1}, 32'h0);
      check({28'h0, output_terminal}, {28'h0, out_state});
      apb(1'b0, `SEL_ADDR_STATUS, 32'h0);
      check({31'h0, rd[7]}, 32'h0);
      $display("test mid reset done");
      tally_and_finish();
   end
endmodule : test_latch_input_select_output_invert
